// file: dic_chan_if.sv
// Interface carrying conditioned samples and settings to the delay filter
`timescale 1ns/1ps
interface dic_chan_if;
  import dic_pkg::*;
  logic ms_tick;
  logic [N_CH-1:0] smp;
  logic [N_CH-1:0] ac;
  logic [DLY_W-1:0] act [N_CH];
  logic [DLY_W-1:0] drop [N_CH];
  logic [N_CH-1:0] st;

  modport ctl (output ms_tick, smp, ac, act, drop, input st);
  modport flt (input ms_tick, smp, ac, act, drop, output st);
endinterface

// file: dic_field_model.sv
// Field contact model driving the digital input terminals
`timescale 1ns/1ps
module dic_field_model import dic_pkg::*; (
  // Clock
  input wire logic i_mclk,
  // Terminal energized levels
  output logic [N_CH-1:0] o_terminal
);
  // ********************************************************
  // Contact behaviour
  // ********************************************************
  // All contacts open at power up
  initial o_terminal = '0;

  // Energize or release one contact just after a clock edge
  task automatic set_ch(input int ch, input logic lvl);
    @(posedge i_mclk);
    o_terminal[ch] <= lvl;
  endtask

  // Short closure, as a chattering contact would give
  task automatic pulse(input int ch, input int clks);
    set_ch(ch, 1'b1);
    repeat (clks) @(posedge i_mclk);
    o_terminal[ch] <= 1'b0;
  endtask
endmodule // dic_field_model

// file: dic_filter.sv
// Per-channel activation and drop-off delay filter
`timescale 1ns/1ps
module dic_filter import dic_pkg::*; (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Samples, settings and filtered state
  dic_chan_if.flt chan
);

  dic_flt_st_t st_r [N_CH];
  logic [CNT_W-1:0] cnt_r [N_CH];
  logic [N_CH-1:0] lvl_r;
  logic [CNT_W-1:0] tgt [N_CH];
  logic [N_CH-1:0] hit;

  // Delay target picked by the direction of the pending change
  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      if (chan.smp[i]) begin
        tgt[i] = {1'b0, chan.act[i]}; // RL3
      end else begin
        tgt[i] = {1'b0, chan.drop[i]} + (chan.ac[i] ? AC_DLY_MS : '0); // RL4 RL5
      end
      hit[i] = (cnt_r[i] >= tgt[i]);
    end
  end

  // Timer and level; a revert clears the timer so only held changes pass
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      lvl_r <= '0;
      for (int i = 0; i < N_CH; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_CH; i++) begin
        if (chan.smp[i] == lvl_r[i]) begin
          cnt_r[i] <= '0; // RL8
        end else if (hit[i]) begin
          lvl_r[i] <= chan.smp[i]; // RL3 RL4
          cnt_r[i] <= '0;
        end else if (chan.ms_tick) begin
          cnt_r[i] <= cnt_r[i] + 1'b1; // RL8
        end
      end
    end
  end

  // Pending flag, kept for visibility of a running timer
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < N_CH; i++) begin
        st_r[i] <= DIC_STABLE;
      end
    end else begin
      for (int i = 0; i < N_CH; i++) begin
        case (st_r[i])
          DIC_STABLE: st_r[i] <= (chan.smp[i] != lvl_r[i] && !hit[i]) ?
                                 DIC_PEND : DIC_STABLE;
          DIC_PEND: st_r[i] <= (chan.smp[i] == lvl_r[i] || hit[i]) ?
                               DIC_STABLE : DIC_PEND;
          default: st_r[i] <= DIC_STABLE;
        endcase
      end
    end
  end

  assign chan.st = lvl_r;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  for (genvar g = 0; g < N_CH; g++) begin : g_chk
    property p_act_rise;
      (!lvl_r[g] && chan.smp[g] && cnt_r[g] >= {1'b0, chan.act[g]})
        |=> lvl_r[g];
    endproperty
    a_act_rise: assert property (p_act_rise) // RL3
      else $error("input did not rise at activation expiry");

    property p_act_wait;
      (!lvl_r[g] && chan.smp[g] && cnt_r[g] < {1'b0, chan.act[g]})
        |=> !lvl_r[g];
    endproperty
    a_act_wait: assert property (p_act_wait) // RL3
      else $error("input rose before activation delay");

    property p_drop_fall;
      (lvl_r[g] && !chan.smp[g] && !chan.ac[g] &&
       cnt_r[g] >= {1'b0, chan.drop[g]}) |=> !lvl_r[g];
    endproperty
    a_drop_fall: assert property (p_drop_fall) // RL4
      else $error("input did not fall at drop-off expiry");

    property p_ac_hold;
      (lvl_r[g] && !chan.smp[g] && chan.ac[g] &&
       cnt_r[g] < {1'b0, chan.drop[g]} + AC_DLY_MS) |=> lvl_r[g];
    endproperty
    a_ac_hold: assert property (p_ac_hold) // RL5
      else $error("ac mode input dropped before extra delay");

    sequence s_revert;
      lvl_r[g] != chan.smp[g] ##1 lvl_r[g] == chan.smp[g];
    endsequence
    property p_revert;
      s_revert |=> cnt_r[g] == '0;
    endproperty
    a_revert: assert property (p_revert) // RL8
      else $error("timer not restarted on revert");

    property p_pend_flag;
      (chan.smp[g] != lvl_r[g] && !hit[g]) |=> st_r[g] == DIC_PEND;
    endproperty
    a_pend_flag: assert property (p_pend_flag) // RL8
      else $error("pending flag not set while timer runs");
  end

endmodule // dic_filter

// file: dic_pkg.sv
// Constants, field layout and types of the digital input conditioning block
package dic_pkg;

  // ********************************************************
  // Channel count and timing
  // ********************************************************
  localparam int N_CH = 3;
  localparam int DLY_W = 21;
  localparam int CNT_W = DLY_W + 1;
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS = 1;
  // Clocks in one 1 ms delay tick, derived from the clock rate
  localparam int MS_CLKS = CLK_HZ / 1000 * TICK_MS;
  localparam int CYC_TIME_MS = 5;
  localparam logic [2:0] CYC_MS_LAST = 3'(CYC_TIME_MS / TICK_MS - 1);
  localparam logic [DLY_W-1:0] DLY_MAX_MS = 21'h1b7740;
  localparam int AC_TIME_MS = 30;
  localparam logic [CNT_W-1:0] AC_DLY_MS = CNT_W'(AC_TIME_MS / TICK_MS);

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_ACT0 = 8'h10;
  localparam logic [7:0] ADDR_DROP0 = 8'h20;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int CFG_POL_LSB = 0;
  localparam int CFG_AC_LSB = 8;
  localparam int CFG_ROUTE_LSB = 16;
  localparam int STAT_SMP_LSB = 0;
  localparam int STAT_FLT_LSB = 8;
  localparam int STAT_REP_LSB = 16;
  localparam int STAT_OUT_LSB = 24;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [N_CH-1:0] POL_RST = 3'h0;
  localparam logic [N_CH-1:0] AC_RST = 3'h0;
  localparam logic [N_CH-1:0] ROUTE_RST = 3'h0;
  localparam logic [DLY_W-1:0] DLY_RST = 21'h0;

  // Per-channel filter state
  typedef enum logic {
    DIC_STABLE = 1'b0,
    DIC_PEND = 1'b1
  } dic_flt_st_t;

endpackage

// file: dic_top.sv
// Digital input conditioning: sampling, polarity, delays, output routing
//
// Overview of operation
// [RL1] Inputs are sampled once every 5 ms program cycle.
// [RL2] Per-channel polarity picks normally open or closed; open after reset.
// [RL3] A 0 to 1 change is held off by the activation delay, 1 ms steps.
// [RL4] A 1 to 0 change is held off by the drop-off delay, 1 ms steps.
// [RL5] AC mode adds a fixed 30 ms to the drop-off delay; off by default.
// [RL6] Internal users see the filtered state at the next cycle boundary.
// [RL7] A directly routed output follows one further 5 ms cycle later.
// [RL8] Delay timers count 1 ms ticks and restart if the sample reverts.
`timescale 1ns/1ps
module dic_top import dic_pkg::*; #(
  parameter int MS_CLK_CNT = MS_CLKS
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Energized state of each digital input channel terminal
  input wire logic [N_CH-1:0] i_digital_input_channel,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Conditioned state and routed outputs
  output logic [N_CH-1:0] o_di_state,
  output logic [N_CH-1:0] o_digital_output_channel
);

  // ********************************************************
  // Declarations
  // ********************************************************
  dic_chan_if chan ();
  logic [N_CH-1:0] pol_r;
  logic [N_CH-1:0] ac_r;
  logic [N_CH-1:0] route_r;
  logic [DLY_W-1:0] act_r [N_CH];
  logic [DLY_W-1:0] drop_r [N_CH];
  logic [31:0] ms_cnt_r;
  logic ms_tick_r;
  logic [2:0] cyc_cnt_r;
  logic cyc_tick_r;
  logic [N_CH-1:0] smp_r;
  logic [31:0] rdata_nxt;

  // Word in a bank of per-channel registers
  function automatic logic in_bank(input logic [7:0] a,
                                   input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return (a >= base) && (d[1:0] == 2'h0) && (d[7:2] < 6'(N_CH));
  endfunction

  function automatic int bank_idx(input logic [7:0] a,
                                  input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return int'(d[7:2]);
  endfunction

  // Oversized settings saturate at the longest allowed delay
  function automatic logic [DLY_W-1:0] clamp_dly(input logic [31:0] v);
    return (v > 32'(DLY_MAX_MS)) ? DLY_MAX_MS : v[DLY_W-1:0];
  endfunction

  // ********************************************************
  // Time base
  // ********************************************************
  // 1 ms tick from the 20 MHz clock
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ms_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (ms_cnt_r == 32'(MS_CLK_CNT - 1));
      ms_cnt_r <= (ms_cnt_r == 32'(MS_CLK_CNT - 1)) ? '0 : ms_cnt_r + 1;
    end
  end

  // Program cycle tick every fifth ms tick
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cyc_cnt_r <= '0;
      cyc_tick_r <= 1'b0;
    end else begin
      cyc_tick_r <= ms_tick_r && (cyc_cnt_r == CYC_MS_LAST); // RL1
      if (ms_tick_r) begin
        cyc_cnt_r <= (cyc_cnt_r == CYC_MS_LAST) ? '0 : cyc_cnt_r + 3'h1;
      end
    end
  end

  // ********************************************************
  // Sampling and cycle-latched outputs
  // ********************************************************
  // Terminals are only looked at once per cycle; polarity folded in
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      smp_r <= '0;
    end else if (cyc_tick_r) begin
      smp_r <= i_digital_input_channel ^ pol_r; // RL1 RL2
    end
  end

  // Users get the filtered state at the next boundary, outputs one later
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_di_state <= '0;
      o_digital_output_channel <= '0;
    end else if (cyc_tick_r) begin
      o_di_state <= chan.st; // RL6
      o_digital_output_channel <= o_di_state & route_r; // RL7
    end
  end

  assign chan.ms_tick = ms_tick_r;
  assign chan.smp = smp_r;
  assign chan.ac = ac_r;
  assign chan.act = act_r;
  assign chan.drop = drop_r;

  dic_filter u_filter (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .chan(chan.flt)
  );

  // ********************************************************
  // Register port
  // ********************************************************
  // Configuration word
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pol_r <= POL_RST; // RL2
      ac_r <= AC_RST; // RL5
      route_r <= ROUTE_RST;
    end else if (i_wr && i_addr == ADDR_CFG) begin
      pol_r <= i_wdata[CFG_POL_LSB +: N_CH]; // RL2
      ac_r <= i_wdata[CFG_AC_LSB +: N_CH]; // RL5
      route_r <= i_wdata[CFG_ROUTE_LSB +: N_CH];
    end
  end

  // Delay settings in milliseconds
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < N_CH; i++) begin
        act_r[i] <= DLY_RST;
        drop_r[i] <= DLY_RST;
      end
    end else if (i_wr) begin
      if (in_bank(i_addr, ADDR_ACT0)) begin
        act_r[bank_idx(i_addr, ADDR_ACT0)] <= clamp_dly(i_wdata); // RL3
      end
      if (in_bank(i_addr, ADDR_DROP0)) begin
        drop_r[bank_idx(i_addr, ADDR_DROP0)] <= clamp_dly(i_wdata); // RL4
      end
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rdata_nxt = '0;
    if (i_addr == ADDR_CFG) begin
      rdata_nxt[CFG_POL_LSB +: N_CH] = pol_r;
      rdata_nxt[CFG_AC_LSB +: N_CH] = ac_r;
      rdata_nxt[CFG_ROUTE_LSB +: N_CH] = route_r;
    end else if (i_addr == ADDR_STAT) begin
      rdata_nxt[STAT_SMP_LSB +: N_CH] = smp_r;
      rdata_nxt[STAT_FLT_LSB +: N_CH] = chan.st;
      rdata_nxt[STAT_REP_LSB +: N_CH] = o_di_state;
      rdata_nxt[STAT_OUT_LSB +: N_CH] = o_digital_output_channel;
    end else if (in_bank(i_addr, ADDR_ACT0)) begin
      rdata_nxt[DLY_W-1:0] = act_r[bank_idx(i_addr, ADDR_ACT0)];
    end else if (in_bank(i_addr, ADDR_DROP0)) begin
      rdata_nxt[DLY_W-1:0] = drop_r[bank_idx(i_addr, ADDR_DROP0)];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rdata_nxt : '0;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  property p_sample_pol;
    cyc_tick_r |=> smp_r == $past(i_digital_input_channel ^ pol_r);
  endproperty
  a_sample_pol: assert property (p_sample_pol) // RL1 RL2
    else $error("sample does not match terminal and polarity");

  property p_sample_hold;
    !cyc_tick_r |=> $stable(smp_r);
  endproperty
  a_sample_hold: assert property (p_sample_hold) // RL1
    else $error("sample changed between cycle ticks");

  sequence s_cycle_gap;
    cyc_tick_r ##1 !cyc_tick_r [*4];
  endsequence
  property p_cycle_gap;
    cyc_tick_r |-> s_cycle_gap;
  endproperty
  a_cycle_gap: assert property (p_cycle_gap) // RL1
    else $error("cycle ticks too close");

  property p_state_update;
    cyc_tick_r |=> o_di_state == $past(chan.st);
  endproperty
  a_state_update: assert property (p_state_update) // RL6
    else $error("internal state not taken at cycle tick");

  property p_out_lag;
    cyc_tick_r |=> o_digital_output_channel ==
                   ($past(o_di_state) & $past(route_r));
  endproperty
  a_out_lag: assert property (p_out_lag) // RL7
    else $error("routed output not one cycle behind state");

endmodule // dic_top

// file: dic_top_test.sv
// Self-checking testbench of the digital input conditioning block
`timescale 1ns/1ps
module dic_top_test import dic_pkg::*;;
  // ********************************************************
  // Signals and bench state
  // ********************************************************
  // Short ms tick keeps the run brief; windows derive from it
  localparam int MSC = 4;
  localparam int CYC = MSC * CYC_TIME_MS;
  localparam int SLACK = 3 * CYC + 8;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [N_CH-1:0] o_di_state;
  logic [N_CH-1:0] o_digital_output_channel;
  logic [N_CH-1:0] terminal;
  int num_errors = 0;
  int cmp_count = 0;
  logic [31:0] exp_q[$];
  logic rd_q = 1'b0;
  logic [31:0] rnd = 32'h3709b104;

  // 20 MHz clock
  always #25 i_mclk = ~i_mclk;

  dic_field_model dic_field_model_i (.i_mclk(i_mclk), .o_terminal(terminal));
  dic_top #(.MS_CLK_CNT(MSC)) dic_top_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_digital_input_channel(terminal), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_di_state(o_di_state),
    .o_digital_output_channel(o_digital_output_channel));

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [31:0] xrand();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Idle cycle between strobes avoids double assignment in one step
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask

  // Waits for a state bit; elapsed clocks must lie in the window
  task automatic wait_bit(input string what, input int ch, input logic v,
                          input int lo, input int hi);
    int n;
    n = 0;
    while (o_di_state[ch] !== v && n <= hi) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (n < lo || n > hi) $display("[ERR] %s after %0d clocks", what, n);
    check(what, 32'h1, 32'(n >= lo && n <= hi));
  endtask

  task automatic step(input string what, input int ch, input logic lvl,
                      input logic v, input int lo, input int hi);
    dic_field_model_i.set_ch(ch, lvl);
    wait_bit(what, ch, v, lo, hi);
  endtask

  // Read data stand only in the cycle after the read strobe, zero elsewhere
  always @(posedge i_mclk) begin
    if (rd_q) begin
      if (exp_q.size() == 0) check("read queue", 32'h1, 32'h0);
      else check("rdata", exp_q.pop_front(), o_rdata);
    end else if (i_nrst) begin
      check("rdata idle", 32'h0, o_rdata);
    end
    rd_q = i_rd;
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    int n;
    int d;
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    // Reset values, unmapped place, saturation of delays
    reg_rd(ADDR_CFG, 32'h0);
    for (int i = 0; i < N_CH; i++) begin
      reg_rd(ADDR_ACT0 + 8'(4 * i), 32'h0);
      reg_rd(ADDR_DROP0 + 8'(4 * i), 32'h0);
    end
    reg_wr(8'h08, 32'hffffffff);
    reg_rd(8'h08, 32'h0);
    reg_rd(ADDR_STAT, 32'h0);
    reg_wr(ADDR_ACT0, {11'h0, DLY_MAX_MS});
    reg_rd(ADDR_ACT0, {11'h0, DLY_MAX_MS});
    reg_wr(ADDR_DROP0, 32'h001fffff);
    reg_rd(ADDR_DROP0, {11'h0, DLY_MAX_MS});
    reg_wr(ADDR_ACT0, 32'h0);
    reg_wr(ADDR_DROP0, 32'h0);
    // Zero delay, routed to output one cycle later
    reg_wr(ADDR_CFG, 32'h00010000);
    step("rise ch0", 0, 1'b1, 1'b1, 1, 2 * CYC);
    n = 0;
    while (o_digital_output_channel !== 3'h1 && n <= CYC) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    check("output lag", 32'(CYC), 32'(n));
    reg_rd(ADDR_STAT, 32'h01010101);
    // Normally closed channel
    reg_wr(ADDR_CFG, 32'h00010002);
    wait_bit("nc idle ch1", 1, 1'b1, 0, 2 * CYC + 4);
    step("nc energized ch1", 1, 1'b1, 1'b0, 1, 2 * CYC);
    // Random activation delay, AC mode on drop-off
    d = 5 + int'(xrand() % 16);
    reg_wr(ADDR_ACT0 + 8'h08, 32'(d));
    reg_wr(ADDR_CFG, 32'h00010402);
    step("act ch2", 2, 1'b1, 1'b1, (d - 1) * MSC, d * MSC + SLACK);
    n = AC_TIME_MS * MSC;
    step("ac drop ch2", 2, 1'b0, 1'b0, n - MSC, n + SLACK);
    // Plain drop-off delay, no AC added
    d = 3 + int'(xrand() % 8);
    reg_wr(ADDR_DROP0, 32'(d));
    step("drop ch0", 0, 1'b0, 1'b0, (d - 1) * MSC, d * MSC + SLACK);
    // Chatter shorter than activation delay is never reported; three
    // bursts would add up past the delay if the timer did not restart
    reg_wr(ADDR_ACT0, 32'h14);
    n = 0;
    fork
      repeat (3) begin
        dic_field_model_i.pulse(0, 2 * CYC);
        repeat (CYC) @(posedge i_mclk);
      end
      repeat (10 * CYC) begin
        @(posedge i_mclk);
        #1;
        if (o_di_state[0] !== 1'b0) n++;
      end
    join
    check("chatter ch0", 32'h0, 32'(n));
    // Mid-run reset clears outputs and brings back normally open
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    check("reset outs", 32'h0,
          32'({o_di_state, o_digital_output_channel}));
    i_nrst <= 1'b1;
    reg_rd(ADDR_CFG, 32'h0);
    wait_bit("no default ch1", 1, 1'b1, CYC, 2 * CYC + 4);
    repeat (3) @(posedge i_mclk);
    finish_test();
  end

  // Watchdog at over four times the expected run length
  initial begin
    repeat (150 * CYC) @(posedge i_mclk);
    num_errors++;
    $display("[ERR] watchdog expired");
    finish_test();
  end
endmodule // dic_top_test
